// ### nvm_pkg.sv
// Shared constants and helpers for the data EEPROM access logic
package nvm_pkg;

	// I/O space offsets of the device registers
	localparam int             IO_AW          = 6;
	localparam logic [5:0]     OFS_CONTROL    = 6'h1F;
	localparam logic [5:0]     OFS_DATA       = 6'h20;
	localparam logic [5:0]     OFS_ADDR_LOW   = 6'h21;
	localparam logic [5:0]     OFS_ADDR_HIGH  = 6'h22;

	// Control register bit positions
	localparam int             BIT_READ_STB   = 0;
	localparam int             BIT_WRITE_STB  = 1;
	localparam int             BIT_MASTER_WE  = 2;
	localparam int             BIT_READY_IE   = 3;

	// Array geometry
	localparam int             NVM_DEPTH      = 1024;
	localparam int             NVM_AW         = 10;

	// Cycle counts on the CPU clock
	localparam logic [2:0]     HALT_READ_CYC  = 3'h4;
	localparam logic [2:0]     HALT_WRITE_CYC = 3'h2;
	localparam logic [2:0]     MWE_CYC        = 3'h4;

	// Programming time: oscillator cycles and typical duration
	localparam int             CLK_PERIOD_NS  = 10;
	localparam int             PROG_TIME_US   = 3400;
	localparam int             PROG_OSC_CYC   = 27072;
	localparam int             OSC_DIV        =
		(PROG_TIME_US * 1000) / (PROG_OSC_CYC * CLK_PERIOD_NS);

	// Host command port offsets and bits
	localparam logic [7:0]     HOFS_ADDR_LO   = 8'h00;
	localparam logic [7:0]     HOFS_ADDR_HI   = 8'h01;
	localparam logic [7:0]     HOFS_DATA      = 8'h02;
	localparam logic [7:0]     HOFS_CTRL      = 8'h03;
	localparam logic [7:0]     HOFS_STATUS    = 8'h04;
	localparam logic [7:0]     HOFS_MASK      = 8'h05;
	localparam int             HBIT_START_RD  = 0;
	localparam int             HBIT_START_WR  = 1;
	localparam int             HBIT_GIE       = 2;
	localparam int             HBIT_RIE       = 3;
	localparam int             HEV_W          = 3;

	// Control byte as seen on the I/O bus, reserved bits zero
	function automatic logic [7:0] nvm_ctrl_byte(input logic rie, input logic mwe,
		input logic ws, input logic rs);
		nvm_ctrl_byte = {4'h0, rie, mwe, ws, rs};
	endfunction : nvm_ctrl_byte

endpackage : nvm_pkg

// ### nvm_if.sv
// Interface joining the CPU-side host end and the EEPROM device end
`timescale 1ns/1ns
interface nvm_if;
	logic [5:0] io_addr;
	logic [7:0] io_wdata;
	logic       io_wr;
	logic       io_rd;
	logic [7:0] io_rdata;
	logic       cpu_halt;
	logic       ready_irq;
	logic       global_irq_en;
	logic       self_program_enable;

	modport device (
		input  io_addr, io_wdata, io_wr, io_rd, global_irq_en, self_program_enable,
		output io_rdata, cpu_halt, ready_irq
	);
	modport host (
		output io_addr, io_wdata, io_wr, io_rd, global_irq_en, self_program_enable,
		input  io_rdata, cpu_halt, ready_irq
	);
endinterface : nvm_if

// ### nvm_prog_timer.sv
// Programming timer on clk_sys, counting divided-down oscillator ticks
`timescale 1ns/1ns
module nvm_prog_timer
	import nvm_pkg::*;
#(
	parameter int OSC_DIV_P    = OSC_DIV,
	parameter int OSC_CYCLES_P = PROG_OSC_CYC
) (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic resetn,
	// Control
	input  wire logic start,
	output logic      busy,
	output logic      done
);
	localparam int DW = $clog2(OSC_DIV_P + 1);
	localparam int CW = $clog2(OSC_CYCLES_P + 1);
	localparam logic [DW-1:0] DIV_LOAD = DW'(OSC_DIV_P - 1);
	localparam logic [CW-1:0] CYC_LOAD = CW'(OSC_CYCLES_P - 1);

	typedef struct packed {
		logic [DW-1:0] div;
		logic [CW-1:0] cyc;
		logic          busy;
		logic          done;
	} nvm_tmr_st_t;

	nvm_tmr_st_t r;
	nvm_tmr_st_t n;

	// Refuse settings that give no tick
	if (OSC_DIV_P < 1 || OSC_CYCLES_P < 1) begin : g_chk
		$error("nvm_prog_timer: divider and cycle count must be at least one");
	end

	// Count oscillator ticks until the programming time has elapsed
	always_comb begin
		n = r;
		n.done = 1'b0;
		if (start) begin
			n.busy = 1'b1;
			n.div = DIV_LOAD;
			n.cyc = CYC_LOAD;
		end else if (r.busy) begin
			if (r.div == '0) begin
				n.div = DIV_LOAD;
				if (r.cyc == '0) begin
					n.busy = 1'b0;
					n.done = 1'b1;
				end else begin
					n.cyc = r.cyc - 1'b1;
				end
			end else begin
				n.div = r.div - 1'b1;
			end
		end
	end

	// State register
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign busy = r.busy;
	assign done = r.done;
endmodule : nvm_prog_timer

// ### nvm_device.sv
// Device end: EEPROM array with address, data and control registers
//
// Summary of operation
// [R1] Read strobe halts CPU four cycles
// [R2] Write strobe halts CPU two cycles
// [R3] Ten-bit address across low/high registers
// [R4] Address bits 15:10 read zero
// [R5] Control bits 7:4 read zero
// [R6] Software loads address before any access
// [R7] Data register supplies and receives bytes
// [R8] Ready interrupt while enabled and idle
// [R9] Master enable self-clears after four cycles
// [R10] Write strobe needs master enable set
// [R11] Write strobe holds until programming ends
// [R12] Write timed by 27072 oscillator cycles
// [R13] No write during flash self-programming
// [R14] Read result lands in data immediately
// [R15] Busy: ignore reads, freeze address
// [R16] Software sequence: poll, load, enable, strobe
// [R17] Software avoids interrupts during sequence
// [R18] Software polls write strobe before reading
// [R19] Master enable ignored while programming
`timescale 1ns/1ns
module nvm_device
	import nvm_pkg::*;
#(
	parameter int OSC_DIV_P    = OSC_DIV,
	parameter int OSC_CYCLES_P = PROG_OSC_CYC
) (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic resetn,
	// CPU I/O side
	nvm_if.device     bus,
	// Status toward the rest of the chip
	output logic      prog_active,
	output logic      prog_done
);
	typedef enum logic [1:0] {
		DEV_IDLE = 2'b01,
		DEV_PROG = 2'b10
	} nvm_dev_state_t;

	typedef struct packed {
		nvm_dev_state_t    state;
		logic [NVM_AW-1:0] addr;
		logic [7:0]        data;
		logic [7:0]        prog_data;
		logic              rie;
		logic              mwe;
		logic [2:0]        mwe_cnt;
		logic [2:0]        halt_cnt;
		logic              halt;
		logic [7:0]        rdata;
		logic              irq;
		logic              done;
	} nvm_dev_st_t;

	localparam nvm_dev_st_t DEV_RESET = '{
		state: DEV_IDLE, addr: '0, data: 8'h00, prog_data: 8'h00, rie: 1'b0,
		mwe: 1'b0, mwe_cnt: 3'h0, halt_cnt: 3'h0, halt: 1'b0, rdata: 8'h00,
		irq: 1'b0, done: 1'b0};

	nvm_dev_st_t r;
	nvm_dev_st_t n;

	logic [7:0] mem [NVM_DEPTH];
	logic       tmr_start;
	logic       tmr_done;
	logic       idle;
	logic       access;
	logic       ws;

	// Self-timed programming period
	nvm_prog_timer #(
		.OSC_DIV_P    (OSC_DIV_P),
		.OSC_CYCLES_P (OSC_CYCLES_P)
	) u_timer (
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.start   (tmr_start),
		.busy    (),
		.done    (tmr_done)
	);

	assign idle = (r.state == DEV_IDLE);
	assign ws = (r.state == DEV_PROG);
	// Strobes arriving while the CPU is halted are not real accesses
	assign access = !r.halt;

	// Next state of the register file and sequencer
	always_comb begin
		n = r;
		n.done = 1'b0;
		tmr_start = 1'b0;

		// Halt countdown
		if (r.halt_cnt != 3'h0) begin
			n.halt_cnt = r.halt_cnt - 3'h1;
		end

		// Master enable window runs out
		if (r.mwe_cnt != 3'h0) begin
			n.mwe_cnt = r.mwe_cnt - 3'h1;
			if (r.mwe_cnt == 3'h1) begin
				n.mwe = 1'b0; // [R9]
			end
		end

		// Register writes from the CPU
		if (bus.io_wr && access) begin
			if (bus.io_addr == OFS_ADDR_LOW) begin
				if (idle) begin
					n.addr[7:0] = bus.io_wdata; // [R3] [R15]
				end
			end else if (bus.io_addr == OFS_ADDR_HIGH) begin
				if (idle) begin
					n.addr[9:8] = bus.io_wdata[1:0]; // [R3] [R15]
				end
			end else if (bus.io_addr == OFS_DATA) begin
				n.data = bus.io_wdata; // [R7]
			end else if (bus.io_addr == OFS_CONTROL) begin
				n.rie = bus.io_wdata[BIT_READY_IE];
				if (bus.io_wdata[BIT_MASTER_WE] && idle) begin
					n.mwe = 1'b1; // [R19]
					n.mwe_cnt = MWE_CYC; // [R9]
				end
				if (bus.io_wdata[BIT_WRITE_STB] && r.mwe && idle
					&& !bus.self_program_enable) begin
					// Start programming; data is latched so later edits are harmless
					n.state = DEV_PROG; // [R10] [R13]
					n.prog_data = r.data; // [R7]
					n.halt_cnt = HALT_WRITE_CYC; // [R2]
					tmr_start = 1'b1; // [R12]
				end else if (bus.io_wdata[BIT_READ_STB] && idle) begin
					n.data = mem[r.addr]; // [R14] [R15]
					n.halt_cnt = HALT_READ_CYC; // [R1]
				end
			end
		end

		// Programming time elapsed: strobe drops
		if (ws && tmr_done) begin
			n.state = DEV_IDLE; // [R11]
			n.done = 1'b1;
		end

		n.halt = (n.halt_cnt != 3'h0); // [R1] [R2]

		// Register reads, answered in the next cycle
		n.rdata = 8'h00;
		if (bus.io_rd && access) begin
			if (bus.io_addr == OFS_ADDR_LOW) begin
				n.rdata = r.addr[7:0];
			end else if (bus.io_addr == OFS_ADDR_HIGH) begin
				n.rdata = {6'h00, r.addr[9:8]}; // [R4]
			end else if (bus.io_addr == OFS_DATA) begin
				n.rdata = r.data; // [R7]
			end else if (bus.io_addr == OFS_CONTROL) begin
				n.rdata = nvm_ctrl_byte(r.rie, r.mwe, ws, 1'b0); // [R5] [R11]
			end
		end

		// Ready request stands while enabled and not programming
		n.irq = n.rie && bus.global_irq_en && (n.state == DEV_IDLE); // [R8]
	end

	// State register
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			r <= DEV_RESET;
		end else begin
			r <= n;
		end
	end

	// Array update at the end of the programming time
	always_ff @(posedge clk_sys) begin
		if (ws && tmr_done) begin
			mem[r.addr] <= r.prog_data; // [R11]
		end
	end

	// Outputs straight from the state register
	assign bus.io_rdata  = r.rdata;
	assign bus.cpu_halt  = r.halt;
	assign bus.ready_irq = r.irq;
	assign prog_active   = ws;
	assign prog_done     = r.done;
endmodule : nvm_device

// ### nvm_host.sv
// Host end: CPU-side sequencer issuing EEPROM reads and writes
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ns
module nvm_host
	import nvm_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       resetn,
	// Device side
	nvm_if.host             bus,
	// Software command port
	input  wire logic [7:0] sw_addr,
	input  wire logic [7:0] sw_wdata,
	input  wire logic       sw_wr,
	input  wire logic       sw_rd,
	output logic      [7:0] sw_rdata,
	output logic            irq,
	// Flash self-programming in progress
	input  wire logic       self_program_busy
);
	typedef enum logic [12:0] {
		H_IDLE  = 13'h0001, H_POLL  = 13'h0002, H_PWAIT = 13'h0004,
		H_PCHK  = 13'h0008, H_ADL   = 13'h0010, H_ADH   = 13'h0020,
		H_DAT   = 13'h0040, H_MWE   = 13'h0080, H_WE    = 13'h0100,
		H_RE    = 13'h0200, H_RDAT  = 13'h0400, H_RWAIT = 13'h0800,
		H_RCAP  = 13'h1000
	} nvm_host_state_t;

	typedef struct packed {
		nvm_host_state_t  state;
		logic [9:0]       addr;
		logic [7:0]       data;
		logic             op_write;
		logic             gie;
		logic             rie;
		logic [HEV_W-1:0] status;
		logic [HEV_W-1:0] mask;
		logic [7:0]       sw_rdata;
		logic             irq;
		logic [5:0]       io_addr;
		logic [7:0]       io_wdata;
		logic             io_wr;
		logic             io_rd;
		logic             ready_q;
		logic             spm;
	} nvm_host_st_t;

	nvm_host_st_t     r;
	nvm_host_st_t     n;
	logic             quiet;
	logic [HEV_W-1:0] ev;
	logic [HEV_W-1:0] clr;

	// One idle cycle after each access, so a device halt is seen in time
	assign quiet = !bus.cpu_halt && !r.io_wr && !r.io_rd;

	// Sequencer and command registers
	always_comb begin
		n = r;
		n.io_wr = 1'b0;
		n.io_rd = 1'b0;
		n.spm = self_program_busy;
		n.ready_q = bus.ready_irq;
		ev = '0;
		clr = '0;
		case (r.state)
			H_POLL: if (quiet) begin
				n.io_rd = 1'b1;
				n.io_addr = OFS_CONTROL;
				n.state = H_PWAIT;
			end
			H_PWAIT: n.state = H_PCHK;
			H_PCHK: begin
				// Wait for strobe low, and for flash idle before a write
				if (bus.io_rdata[BIT_WRITE_STB] || (r.op_write && r.spm)) begin
					n.state = H_POLL; // [R13] [R16] [R18]
				end else begin
					n.state = H_ADL;
				end
			end
			H_ADL: if (quiet) begin
				n.io_wr = 1'b1;
				n.io_addr = OFS_ADDR_LOW;
				n.io_wdata = r.addr[7:0]; // [R6]
				n.state = H_ADH;
			end
			H_ADH: if (quiet) begin
				n.io_wr = 1'b1;
				n.io_addr = OFS_ADDR_HIGH;
				n.io_wdata = {6'h00, r.addr[9:8]}; // [R6]
				n.state = r.op_write ? H_DAT : H_RE;
			end
			H_DAT: if (quiet) begin
				n.io_wr = 1'b1;
				n.io_addr = OFS_DATA;
				n.io_wdata = r.data;
				n.state = H_MWE;
			end
			H_MWE: if (quiet) begin
				n.io_wr = 1'b1;
				n.io_addr = OFS_CONTROL;
				n.io_wdata = nvm_ctrl_byte(r.rie, 1'b1, 1'b0, 1'b0); // [R16]
				n.state = H_WE;
			end
			H_WE: if (quiet) begin
				// Two cycles after the enable, well inside its window
				n.io_wr = 1'b1;
				n.io_addr = OFS_CONTROL;
				n.io_wdata = nvm_ctrl_byte(r.rie, 1'b1, 1'b1, 1'b0); // [R16] [R17]
				ev[1] = 1'b1;
				n.state = H_IDLE;
			end
			H_RE: if (quiet) begin
				n.io_wr = 1'b1;
				n.io_addr = OFS_CONTROL;
				n.io_wdata = nvm_ctrl_byte(r.rie, 1'b0, 1'b0, 1'b1);
				n.state = H_RDAT;
			end
			H_RDAT: if (quiet) begin
				n.io_rd = 1'b1;
				n.io_addr = OFS_DATA;
				n.state = H_RWAIT;
			end
			H_RWAIT: n.state = H_RCAP;
			H_RCAP: begin
				n.data = bus.io_rdata;
				ev[0] = 1'b1;
				n.state = H_IDLE;
			end
			default: n.state = H_IDLE;
		endcase
		ev[2] = bus.ready_irq && !r.ready_q;

		// Software writes
		if (sw_wr) begin
			if (sw_addr == HOFS_ADDR_LO && r.state == H_IDLE) begin
				n.addr[7:0] = sw_wdata;
			end else if (sw_addr == HOFS_ADDR_HI && r.state == H_IDLE) begin
				n.addr[9:8] = sw_wdata[1:0];
			end else if (sw_addr == HOFS_DATA && r.state == H_IDLE) begin
				n.data = sw_wdata;
			end else if (sw_addr == HOFS_CTRL) begin
				n.gie = sw_wdata[HBIT_GIE];
				n.rie = sw_wdata[HBIT_RIE];
				if (r.state == H_IDLE
					&& (sw_wdata[HBIT_START_RD] || sw_wdata[HBIT_START_WR])) begin
					n.op_write = sw_wdata[HBIT_START_WR];
					n.state = H_POLL;
				end
			end else if (sw_addr == HOFS_STATUS) begin
				clr = sw_wdata[HEV_W-1:0];
			end else if (sw_addr == HOFS_MASK) begin
				n.mask = sw_wdata[HEV_W-1:0];
			end
		end
		// A new event wins over a clear in the same cycle
		n.status = (r.status & ~clr) | ev;
		n.irq = |(n.status & n.mask);

		// Software reads, answered in the next cycle
		n.sw_rdata = 8'h00;
		if (sw_rd) begin
			if (sw_addr == HOFS_ADDR_LO) begin
				n.sw_rdata = r.addr[7:0];
			end else if (sw_addr == HOFS_ADDR_HI) begin
				n.sw_rdata = {6'h00, r.addr[9:8]};
			end else if (sw_addr == HOFS_DATA) begin
				n.sw_rdata = r.data;
			end else if (sw_addr == HOFS_CTRL) begin
				n.sw_rdata = {4'h0, r.rie, r.gie, 1'b0, r.state != H_IDLE};
			end else if (sw_addr == HOFS_STATUS) begin
				n.sw_rdata = {5'h00, r.status};
			end else if (sw_addr == HOFS_MASK) begin
				n.sw_rdata = {5'h00, r.mask};
			end
		end
	end

	// State register
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			r <= '{state: H_IDLE, default: '0};
		end else begin
			r <= n;
		end
	end

	// Outputs straight from the state register
	assign bus.io_addr             = r.io_addr;
	assign bus.io_wdata            = r.io_wdata;
	assign bus.io_wr               = r.io_wr;
	assign bus.io_rd               = r.io_rd;
	assign bus.global_irq_en       = r.gie;
	assign bus.self_program_enable = r.spm;
	assign sw_rdata                = r.sw_rdata;
	assign irq                     = r.irq;
endmodule : nvm_host

// ### nvm_properties.sv
// Concurrent checks on the interface joining the host and device ends
`timescale 1ns/1ns
module nvm_properties
	import nvm_pkg::*;
(
	// Clock and reset
	input wire logic       clk_sys,
	input wire logic       resetn,
	// Interface signals
	input wire logic [5:0] io_addr,
	input wire logic [7:0] io_wdata,
	input wire logic       io_wr,
	input wire logic       io_rd,
	input wire logic [7:0] io_rdata,
	input wire logic       cpu_halt,
	input wire logic       ready_irq,
	input wire logic       global_irq_en,
	input wire logic       self_program_enable
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	// Control write arming the master enable
	sequence s_arm;
		io_wr && io_addr == OFS_CONTROL && io_wdata[BIT_MASTER_WE] && !io_wdata[BIT_WRITE_STB]
			&& !cpu_halt && !self_program_enable;
	endsequence
	// Control write setting the write strobe
	sequence s_strobe;
		io_wr && io_addr == OFS_CONTROL && io_wdata[BIT_WRITE_STB] && !self_program_enable;
	endsequence
	// Control write setting the read strobe
	sequence s_read_go;
		io_wr && io_addr == OFS_CONTROL && io_wdata[BIT_READ_STB]
			&& !io_wdata[BIT_WRITE_STB] && !cpu_halt;
	endsequence

	a_read_halt: assert property (s_read_go |=> cpu_halt [*4] ##1 !cpu_halt)
		else $error("halt after read strobe is not four cycles");
	a_write_halt: assert property (s_arm ##2 s_strobe |=> cpu_halt [*2] ##1 !cpu_halt)
		else $error("halt after write strobe is not two cycles");
	a_irq_in_write: assert property (s_arm ##2 s_strobe |-> ##2 !ready_irq [*2])
		else $error("ready interrupt raised while programming");
	a_irq_needs_gie: assert property (!global_irq_en |=> !ready_irq)
		else $error("ready interrupt without global enable");
	a_ctrl_rsvd: assert property (io_rd && io_addr == OFS_CONTROL |=> io_rdata[7:4] == 4'h0)
		else $error("control reserved bits not zero");
	a_addr_rsvd: assert property (io_rd && io_addr == OFS_ADDR_HIGH |=> io_rdata[7:2] == 6'h00)
		else $error("address high reserved bits not zero");
	a_rdata_idle: assert property (!io_rd |=> io_rdata == 8'h00)
		else $error("read data driven without a read");
	a_no_strobe_halt: assert property (cpu_halt |-> !io_wr && !io_rd)
		else $error("strobe issued while halted");
endmodule : nvm_properties

// ### testbench.sv
// Bench: host joined to a device, plus a second device driven directly
`timescale 1ns/1ns
module testbench;
	import nvm_pkg::*;
	logic       clk_sys = 1'h0;
	logic       resetn = 1'h0;
	logic [7:0] sw_addr = 8'h00;
	logic [7:0] sw_wdata = 8'h00;
	logic       sw_wr = 1'h0, sw_rd = 1'h0, spb = 1'h0;
	logic       rd_chk = 1'h0, rd_chk_q = 1'h0, io_chk = 1'h0, io_chk_q = 1'h0;
	logic [7:0] sw_rdata;
	logic       irq, act1, act2, done1, done2;
	logic [7:0] exp_sw[$], exp_io[$];
	int         miscompares = 0, n_tests = 0;
	int         n_done1 = 0, n_done2 = 0;

	// Clock
	always #5 clk_sys = ~clk_sys;

	nvm_if if1();
	nvm_if if2();
	nvm_host nvm_host_inst (.clk_sys(clk_sys), .resetn(resetn), .bus(if1), .sw_addr(sw_addr),
		.sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .irq(irq),
		.self_program_busy(spb));
	nvm_device #(.OSC_DIV_P(1), .OSC_CYCLES_P(8)) nvm_device_inst (.clk_sys(clk_sys),
		.resetn(resetn), .bus(if1), .prog_active(act1), .prog_done(done1));
	nvm_device #(.OSC_DIV_P(1), .OSC_CYCLES_P(8)) nvm_device_inst2 (.clk_sys(clk_sys),
		.resetn(resetn), .bus(if2), .prog_active(act2), .prog_done(done2));
	nvm_properties nvm_properties_inst (.clk_sys(clk_sys), .resetn(resetn),
		.io_addr(if1.io_addr), .io_wdata(if1.io_wdata), .io_wr(if1.io_wr), .io_rd(if1.io_rd),
		.io_rdata(if1.io_rdata), .cpu_halt(if1.cpu_halt), .ready_irq(if1.ready_irq),
		.global_irq_en(if1.global_irq_en), .self_program_enable(if1.self_program_enable));

	// Compare one value and count it
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic finish_test;
		$display("Comparisons %0d miscompares %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : finish_test

	// One software port access; a checked read notes its expected byte
	task automatic sw_op(input logic w, input logic [7:0] a, input logic [7:0] d,
		input logic c, output logic [7:0] v);
		@(posedge clk_sys);
		sw_wr <= w;
		sw_rd <= !w;
		sw_addr <= a;
		sw_wdata <= d;
		rd_chk <= c;
		if (c) exp_sw.push_back(d);
		@(posedge clk_sys);
		sw_wr <= 1'h0;
		sw_rd <= 1'h0;
		rd_chk <= 1'h0;
		#1 v = sw_rdata;
	endtask : sw_op

	// Poll the host until it is no longer busy
	task automatic host_wait;
		logic [7:0] v;
		for (int i = 0; i < 300; i++) begin
			sw_op(1'h0, HOFS_CTRL, 8'h00, 1'h0, v);
			if (v[HBIT_START_RD] === 1'h0) return;
		end
		miscompares++;
		finish_test();
	endtask : host_wait

	// One cycle on the second device bus; signals hold until the next call
	task automatic io(input logic w, input logic r, input logic [5:0] a, input logic [7:0] d,
		input logic c);
		@(posedge clk_sys);
		if2.io_wr <= w;
		if2.io_rd <= r;
		if2.io_addr <= a;
		if2.io_wdata <= d;
		io_chk <= c;
		if (c) exp_io.push_back(d);
	endtask : io

	// Level check settled after the next edge; the level is read there, not at the call
	task automatic chk_lvl(input string what, input logic e);
		logic s;
		@(posedge clk_sys);
		#1;
		if (what == "irq") s = irq;
		else if (what == "ready_irq") s = if2.ready_irq;
		else s = act2;
		chk(what, {7'h00, e}, {7'h00, s});
	endtask : chk_lvl

	// Result watcher: pairs each read answer with the oldest note
	always @(posedge clk_sys) begin
		if (rd_chk_q) chk("sw_rdata", exp_sw.pop_front(), sw_rdata);
		if (io_chk_q) chk("io_rdata", exp_io.pop_front(), if2.io_rdata);
		// Count end-of-programming pulses, one per accepted write
		if (done1 === 1'h1) n_done1++;
		if (done2 === 1'h1) n_done2++;
		rd_chk_q <= rd_chk;
		io_chk_q <= io_chk;
	end

	initial begin
		logic [7:0] v, d2;
		logic [9:0] adr [3];
		logic [7:0] dat [3];
		int i;
		if2.io_wr = 1'h0;
		if2.io_rd = 1'h0;
		if2.io_addr = 6'h00;
		if2.io_wdata = 8'h00;
		if2.global_irq_en = 1'h0;
		if2.self_program_enable = 1'h0;
		v = $urandom(32'h2D01E5C9);
		repeat (5) @(posedge clk_sys);
		resetn <= 1'h1;
		// Host writes at both ends of the array and one random place
		adr[0] = 10'h000;
		adr[1] = 10'h3FF;
		adr[2] = 10'($urandom_range(1, 1022));
		for (i = 0; i < 3; i++) begin
			dat[i] = 8'($urandom);
			sw_op(1'h1, HOFS_ADDR_LO, adr[i][7:0], 1'h0, v);
			sw_op(1'h1, HOFS_ADDR_HI, {6'h00, adr[i][9:8]}, 1'h0, v);
			sw_op(1'h1, HOFS_DATA, dat[i], 1'h0, v);
			spb <= (i == 1);
			sw_op(1'h1, HOFS_CTRL, 8'h02, 1'h0, v);
			repeat (20) @(posedge clk_sys);
			// Still programming, except where flash self-programming held the write off
			#1 chk("prog_active", {7'h00, i != 1}, {7'h00, act1});
			spb <= 1'h0;
			host_wait();
		end
		// Host reads back every byte
		for (i = 0; i < 3; i++) begin
			sw_op(1'h1, HOFS_ADDR_LO, adr[i][7:0], 1'h0, v);
			sw_op(1'h1, HOFS_ADDR_HI, {6'h00, adr[i][9:8]}, 1'h0, v);
			sw_op(1'h1, HOFS_CTRL, 8'h01, 1'h0, v);
			host_wait();
			sw_op(1'h0, HOFS_DATA, dat[i], 1'h1, v);
		end
		// Status, mask and interrupt line; write with ready interrupt and global flag on
		sw_op(1'h1, HOFS_STATUS, 8'h07, 1'h0, v);
		sw_op(1'h1, HOFS_CTRL, 8'h0E, 1'h0, v);
		host_wait();
		sw_op(1'h0, HOFS_STATUS, 8'h06, 1'h1, v);
		chk_lvl("irq", 1'h0);
		sw_op(1'h1, HOFS_MASK, 8'h02, 1'h0, v);
		chk_lvl("irq", 1'h1);
		sw_op(1'h1, HOFS_STATUS, 8'h02, 1'h0, v);
		chk_lvl("irq", 1'h0);
		// Second device: reserved bits and address width
		@(posedge clk_sys);
		if2.global_irq_en <= 1'h1;
		d2 = 8'($urandom);
		io(1'h0, 1'h1, OFS_CONTROL, 8'h00, 1'h1);
		io(1'h1, 1'h0, OFS_ADDR_HIGH, 8'hFF, 1'h0);
		io(1'h0, 1'h1, OFS_ADDR_HIGH, 8'h03, 1'h1);
		io(1'h1, 1'h0, OFS_ADDR_LOW, 8'h5A, 1'h0);
		io(1'h1, 1'h0, OFS_DATA, d2, 1'h0);
		// Master enable window: reads one for four cycles, then clears
		io(1'h1, 1'h0, OFS_CONTROL, 8'h04, 1'h0);
		for (i = 1; i < 6; i++) io(1'h0, 1'h1, OFS_CONTROL, (i < 5) ? 8'h04 : 8'h00, 1'h1);
		io(1'h1, 1'h0, OFS_CONTROL, 8'h02, 1'h0);
		io(1'h0, 1'h0, 6'h00, 8'h00, 1'h0);
		chk_lvl("prog_active", 1'h0);
		// Strobe refused while flash self-programming is busy
		if2.self_program_enable <= 1'h1;
		io(1'h1, 1'h0, OFS_CONTROL, 8'h04, 1'h0);
		io(1'h1, 1'h0, OFS_CONTROL, 8'h06, 1'h0);
		io(1'h0, 1'h0, 6'h00, 8'h00, 1'h0);
		chk_lvl("prog_active", 1'h0);
		if2.self_program_enable <= 1'h0;
		repeat (4) io(1'h0, 1'h0, 6'h00, 8'h00, 1'h0);
		// Write with the strobe on the last cycle of the window
		io(1'h1, 1'h0, OFS_CONTROL, 8'h0C, 1'h0);
		repeat (3) io(1'h0, 1'h0, 6'h00, 8'h00, 1'h0);
		io(1'h1, 1'h0, OFS_CONTROL, 8'h0E, 1'h0);
		repeat (2) io(1'h0, 1'h0, 6'h00, 8'h00, 1'h0);
		chk_lvl("ready_irq", 1'h0);
		io(1'h1, 1'h0, OFS_ADDR_LOW, 8'h11, 1'h0);
		io(1'h1, 1'h0, OFS_CONTROL, 8'h0D, 1'h0);
		io(1'h0, 1'h1, OFS_CONTROL, 8'h0A, 1'h1);
		io(1'h0, 1'h0, 6'h00, 8'h00, 1'h0);
		for (i = 0; i < 200 && act2 === 1'h1; i++) @(posedge clk_sys);
		if (i == 200) begin
			miscompares++;
			finish_test();
		end
		io(1'h0, 1'h1, OFS_CONTROL, 8'h08, 1'h1);
		io(1'h0, 1'h1, OFS_ADDR_LOW, 8'h5A, 1'h1);
		io(1'h1, 1'h0, OFS_DATA, 8'h00, 1'h0);
		io(1'h1, 1'h0, OFS_CONTROL, 8'h09, 1'h0);
		repeat (4) io(1'h0, 1'h0, 6'h00, 8'h00, 1'h0);
		io(1'h0, 1'h1, OFS_DATA, d2, 1'h1);
		io(1'h0, 1'h0, 6'h00, 8'h00, 1'h0);
		chk_lvl("ready_irq", 1'h1);
		repeat (3) @(posedge clk_sys);
		// Four writes through the host, one accepted on the second device
		chk("prog_done", 8'h04, 8'(n_done1));
		chk("prog_done", 8'h01, 8'(n_done2));
		finish_test();
	end
endmodule : testbench
